// *** src/frc_defines.svh ***
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH
`define FRC_ADDR_CTRL 12'h000
`define FRC_ADDR_READ_MODE 12'h004
`define FRC_ADDR_AE_CTRL 12'h008
`define FRC_ADDR_AE_TARGET 12'h00c
`define FRC_ADDR_COARSE 12'h010
`define FRC_ADDR_FINE 12'h014
`define FRC_ADDR_GAIN 12'h018
`define FRC_ADDR_FRAME_LINES 12'h01c
`define FRC_ADDR_LINE_PCK 12'h020
`define FRC_ADDR_STATUS 12'h024
`define FRC_ADDR_AE_RESULT 12'h028
`define FRC_ADDR_RESAMPLE 12'h02c
`define FRC_CTRL_RESTART 1
`define FRC_CTRL_STREAM 2
`define FRC_CTRL_EMBED 3
`define FRC_CTRL_SINGLE 4
`define FRC_RM_COL_MIRROR 14
`define FRC_RM_ROW_MIRROR 15
`define FRC_RESAMPLE_BIT 4
`define FRC_AE_TARGET_RST 16'h0800
`define FRC_COARSE_RST 16'h0010
`define FRC_GAIN_RST 16'h0020
`define FRC_FRAME_LINES_RST 16'h0020
`define FRC_LINE_PCK_RST 16'h0020
`define FRC_ACTIVE_ROWS 16'h0010
`define FRC_ACTIVE_COLS 16'h0010
`define FRC_TRIG_SEEN 2'h3
`define FRC_EMBED_ROWS 16'h0002
`endif

// *** src/frc_pkg.sv ***
package frc_pkg;
  typedef enum logic [2:0] {FRC_IDLE, FRC_WAIT_TRIG, FRC_BUBBLE, FRC_INTEG, FRC_READ, FRC_VBLANK} frc_state_t;
  typedef struct packed {
    logic [15:0] coarse;
    logic [15:0] fine;
    logic [15:0] gain;
    logic [15:0] frame_lines;
    logic [15:0] line_pck;
    logic col_mirror;
    logic row_mirror;
  } frc_cfg_t;
  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic [15:0] row;
    logic [15:0] col;
    logic embed_row;
    logic stats_row;
  } frc_video_t;
endpackage : frc_pkg

// *** src/frc_readout.sv ***
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "frc_defines.svh"
// Notes on behaviour
// - Column mirror reverses column order, color kept.
// - Row mirror reverses rows, shifts one pixel.
// - Timing field write in video adds bubble.
// - Integration writes apply two frames later.
// - Synchronized fields apply from next frame.
// - Single frame: blank-time writes apply immediately.
// - Unsynchronized fields update at write completion.
// - Restart aborts frame after row, applies writes.
// - Video scans rows for reset then read.
// - Frames repeat while capture request high.
// - Request sampled in blanking, three highs.
// - Illumination strobe high during integration.
// - Shared request keeps sensors aligned.
// - Auto exposure updates every second frame.
// - Manual exposure and gain when disabled.
// - Auto exposure target resets to 0x0800.
// - Auto exposure histograms active-row pixels only, not embedded rows.
// - Embedded rows around active rows together.
// - Stream enable starts streaming output.
module frc_readout import frc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_request,
  input wire logic pixel_out_clock,
  input wire logic [11:0] pixel_in,
  output logic frame_valid_strobe,
  output logic line_valid,
  output logic [15:0] row_addr,
  output logic [15:0] col_addr,
  output logic [11:0] pixel_out,
  output logic flash_strobe,
  output logic row_reset_release
);
  logic [15:0] ctrl_q, read_mode_q, ae_ctrl_q, ae_target_q, resample_q;
  frc_cfg_t shadow_q, active_q, integ_pipe_q;
  logic [1:0] integ_pending_q;
  logic bubble_req_q, restart_q;
  logic [1:0] trig_sync_q;
  logic [1:0] pclk_sync_q;
  logic pclk_prev_q;
  logic [1:0] trig_cnt_q;
  frc_state_t state_q;
  logic [15:0] row_q, col_q, cnt_q, rows_total;
  logic [15:0] ae_coarse_q, ae_gain_q;
  logic [31:0] hist_sum_q;
  logic ae_phase_q;
  logic [15:0] frame_count_q;
  logic tick, apb_wr, apb_rd, frame_end, in_blank;
  logic [15:0] use_coarse, use_gain, embed_rows;
  logic restart_go, restart_pend_q, embed_act_q;
  logic [1:0][11:0] pix_sync_q;

  assign apb_wr = psel && penable && pwrite && clk_en;
  assign apb_rd = psel && !penable && !pwrite;
  assign restart_go = (restart_q || restart_pend_q) && ctrl_q[`FRC_CTRL_STREAM]
    && (state_q != FRC_READ || (tick && col_q == `FRC_ACTIVE_COLS - 16'h0001));
  assign embed_rows = embed_act_q ? `FRC_EMBED_ROWS : 16'h0000;
  assign rows_total = `FRC_ACTIVE_ROWS + embed_rows + embed_rows;
  assign in_blank = !frame_valid_strobe;
  assign use_coarse = ae_ctrl_q[0] ? ae_coarse_q : active_q.coarse;
  assign use_gain = ae_ctrl_q[0] ? ae_gain_q : active_q.gain;
  assign tick = pclk_sync_q[1] && !pclk_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pclk_sync_q <= 2'h0;
      pclk_prev_q <= 1'b0;
      trig_sync_q <= 2'h0;
      pix_sync_q <= '0;
    end else if (clk_en) begin
      pclk_sync_q <= {pclk_sync_q[0], pixel_out_clock};
      pclk_prev_q <= pclk_sync_q[1];
      trig_sync_q <= {trig_sync_q[0], capture_request};
      pix_sync_q <= {pix_sync_q[0], pixel_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= apb_rd || (psel && !penable);
      pslverr <= 1'b0;
      if (apb_rd) begin
        case (paddr)
          `FRC_ADDR_CTRL: prdata <= {16'h0, ctrl_q & 16'hfffd};
          `FRC_ADDR_READ_MODE: prdata <= {16'h0, read_mode_q};
          `FRC_ADDR_AE_CTRL: prdata <= {16'h0, ae_ctrl_q};
          `FRC_ADDR_AE_TARGET: prdata <= {16'h0, ae_target_q};
          `FRC_ADDR_COARSE: prdata <= {16'h0, shadow_q.coarse};
          `FRC_ADDR_FINE: prdata <= {16'h0, shadow_q.fine};
          `FRC_ADDR_GAIN: prdata <= {16'h0, shadow_q.gain};
          `FRC_ADDR_FRAME_LINES: prdata <= {16'h0, shadow_q.frame_lines};
          `FRC_ADDR_LINE_PCK: prdata <= {16'h0, shadow_q.line_pck};
          `FRC_ADDR_STATUS: prdata <= {frame_count_q, 13'h0, state_q};
          `FRC_ADDR_AE_RESULT: prdata <= {use_gain, use_coarse};
          `FRC_ADDR_RESAMPLE: prdata <= {16'h0, resample_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 16'h0;
      ae_ctrl_q <= 16'h0;
      ae_target_q <= `FRC_AE_TARGET_RST;
      resample_q <= 16'h0;
      restart_q <= 1'b0;
      bubble_req_q <= 1'b0;
      read_mode_q <= 16'h0;
      shadow_q <= '{`FRC_COARSE_RST, 16'h0, `FRC_GAIN_RST, `FRC_FRAME_LINES_RST, `FRC_LINE_PCK_RST, 1'b0, 1'b0};
    end else if (clk_en) begin
      restart_q <= 1'b0;
      if (state_q == FRC_BUBBLE) begin
        bubble_req_q <= 1'b0;
      end
      if (apb_wr) begin
        case (paddr)
          `FRC_ADDR_CTRL: begin
            ctrl_q <= pwdata[15:0] & 16'hfffd;
            restart_q <= pwdata[`FRC_CTRL_RESTART];
          end
          `FRC_ADDR_AE_CTRL: ae_ctrl_q <= pwdata[15:0];
          `FRC_ADDR_AE_TARGET: ae_target_q <= pwdata[15:0];
          `FRC_ADDR_RESAMPLE: resample_q <= pwdata[15:0];
          `FRC_ADDR_READ_MODE: begin
            read_mode_q <= pwdata[15:0];
            shadow_q.col_mirror <= pwdata[`FRC_RM_COL_MIRROR];
            shadow_q.row_mirror <= pwdata[`FRC_RM_ROW_MIRROR];
            bubble_req_q <= !ctrl_q[`FRC_CTRL_SINGLE];
          end
          `FRC_ADDR_COARSE: begin
            shadow_q.coarse <= pwdata[15:0];
            bubble_req_q <= !ctrl_q[`FRC_CTRL_SINGLE];
          end
          `FRC_ADDR_FINE: begin
            shadow_q.fine <= pwdata[15:0];
            bubble_req_q <= !ctrl_q[`FRC_CTRL_SINGLE];
          end
          `FRC_ADDR_GAIN: shadow_q.gain <= pwdata[15:0];
          `FRC_ADDR_FRAME_LINES: begin
            shadow_q.frame_lines <= pwdata[15:0];
            bubble_req_q <= !ctrl_q[`FRC_CTRL_SINGLE];
          end
          `FRC_ADDR_LINE_PCK: begin
            shadow_q.line_pck <= pwdata[15:0];
            bubble_req_q <= !ctrl_q[`FRC_CTRL_SINGLE];
          end
          default: ;
        endcase
      end
    end
  end

  // Frame-synchronized copy taken at the end of each frame, or at once on restart.
  assign frame_end = tick && state_q == FRC_READ && row_q == rows_total - 16'h0001 && col_q == `FRC_ACTIVE_COLS - 16'h0001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= '{`FRC_COARSE_RST, 16'h0, `FRC_GAIN_RST, `FRC_FRAME_LINES_RST, `FRC_LINE_PCK_RST, 1'b0, 1'b0};
      integ_pipe_q <= '0;
      embed_act_q <= 1'b0;
      integ_pending_q <= 2'h0;
    end else if (clk_en) begin
      if (restart_q || (ctrl_q[`FRC_CTRL_SINGLE] && in_blank && state_q == FRC_WAIT_TRIG)) begin
        active_q <= shadow_q;
        integ_pending_q <= 2'h0;
      end else if (frame_end) begin
        active_q.gain <= shadow_q.gain;
        active_q.frame_lines <= shadow_q.frame_lines;
        active_q.line_pck <= shadow_q.line_pck;
        active_q.col_mirror <= shadow_q.col_mirror;
        active_q.row_mirror <= shadow_q.row_mirror;
        integ_pipe_q <= shadow_q;
        integ_pending_q <= {integ_pending_q[0], 1'b1};
        if (integ_pending_q[1]) begin
          active_q.coarse <= integ_pipe_q.coarse;
          active_q.fine <= integ_pipe_q.fine;
        end
      end
      if (state_q != FRC_READ) begin
        embed_act_q <= ctrl_q[`FRC_CTRL_EMBED];
      end
    end
  end

  // Acquisition sequencer: integration then readout, counted in pixel clock ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FRC_IDLE;
      row_q <= 16'h0;
      col_q <= 16'h0;
      cnt_q <= 16'h0;
      trig_cnt_q <= 2'h0;
      frame_count_q <= 16'h0;
      restart_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == FRC_WAIT_TRIG && in_blank) begin
        trig_cnt_q <= trig_sync_q[1] ? ((trig_cnt_q == `FRC_TRIG_SEEN) ? trig_cnt_q : trig_cnt_q + 2'h1) : 2'h0;
      end else begin
        trig_cnt_q <= 2'h0;
      end
      restart_pend_q <= (restart_q || restart_pend_q) && ctrl_q[`FRC_CTRL_STREAM] && !restart_go;
      if (restart_go) begin
        state_q <= FRC_INTEG;
        cnt_q <= 16'h0;
        row_q <= 16'h0;
        col_q <= 16'h0;
      end else if (tick || state_q == FRC_IDLE || state_q == FRC_WAIT_TRIG) begin
        case (state_q)
          FRC_IDLE: begin
            if (ctrl_q[`FRC_CTRL_STREAM] || trig_sync_q[1]) begin
              state_q <= ctrl_q[`FRC_CTRL_SINGLE] ? FRC_WAIT_TRIG : FRC_INTEG;
              cnt_q <= 16'h0;
            end
          end
          FRC_WAIT_TRIG: begin
            if (trig_cnt_q == `FRC_TRIG_SEEN) begin
              state_q <= FRC_INTEG;
              cnt_q <= 16'h0;
            end else if (!ctrl_q[`FRC_CTRL_SINGLE]) begin
              state_q <= FRC_IDLE;
            end
          end
          FRC_BUBBLE: begin
            cnt_q <= cnt_q + 16'h1;
            if (cnt_q >= use_coarse) begin
              state_q <= FRC_INTEG;
              cnt_q <= 16'h0;
            end
          end
          FRC_INTEG: begin
            cnt_q <= cnt_q + 16'h1;
            if (cnt_q >= use_coarse) begin
              state_q <= FRC_READ;
              row_q <= 16'h0;
              col_q <= 16'h0;
              cnt_q <= 16'h0;
            end
          end
          FRC_READ: begin
            col_q <= col_q + 16'h1;
            if (col_q == `FRC_ACTIVE_COLS - 16'h0001) begin
              col_q <= 16'h0;
              row_q <= row_q + 16'h1;
              if (row_q == rows_total - 16'h0001) begin
                state_q <= FRC_VBLANK;
                cnt_q <= 16'h0;
                frame_count_q <= frame_count_q + 16'h1;
              end
            end
          end
          FRC_VBLANK: begin
            cnt_q <= cnt_q + 16'h1;
            if (cnt_q + rows_total >= active_q.frame_lines) begin
              cnt_q <= 16'h0;
              if (ctrl_q[`FRC_CTRL_SINGLE]) begin
                state_q <= FRC_WAIT_TRIG;
              end else if (!ctrl_q[`FRC_CTRL_STREAM]) begin
                state_q <= FRC_IDLE;
              end else begin
                state_q <= bubble_req_q ? FRC_BUBBLE : FRC_INTEG;
              end
            end
          end
          default: state_q <= FRC_IDLE;
        endcase
      end
    end
  end

  // Auto exposure: sum of active-row pixels, the frame's last pixel left out (embedded rows skipped), compared to target every second frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_sum_q <= 32'h0;
      ae_phase_q <= 1'b0;
      ae_coarse_q <= `FRC_COARSE_RST;
      ae_gain_q <= `FRC_GAIN_RST;
    end else if (clk_en) begin
      if (tick && state_q == FRC_READ && row_q >= embed_rows && row_q < rows_total - embed_rows) begin
        hist_sum_q <= hist_sum_q + {20'h0, pix_sync_q[1]};
      end
      if (frame_end) begin
        ae_phase_q <= !ae_phase_q;
        hist_sum_q <= 32'h0;
        if (ae_ctrl_q[0] && ae_phase_q) begin
          if (hist_sum_q[23:8] < ae_target_q && ae_coarse_q != 16'hffff) begin
            ae_coarse_q <= ae_coarse_q + 16'h1;
          end else if (hist_sum_q[23:8] > ae_target_q && ae_coarse_q > 16'h0001) begin
            ae_coarse_q <= ae_coarse_q - 16'h1;
          end
        end
      end
    end
  end

  // Outputs, with mirrored addressing applied to the row and column counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_valid_strobe <= 1'b0;
      line_valid <= 1'b0;
      row_addr <= 16'h0;
      col_addr <= 16'h0;
      pixel_out <= 12'h0;
      flash_strobe <= 1'b0;
      row_reset_release <= 1'b0;
    end else if (clk_en) begin
      frame_valid_strobe <= state_q == FRC_READ;
      line_valid <= state_q == FRC_READ;
      flash_strobe <= state_q == FRC_INTEG;
      row_reset_release <= state_q == FRC_INTEG && cnt_q == 16'h0;
      col_addr <= active_q.col_mirror ? (`FRC_ACTIVE_COLS - 16'h0001 - col_q) : col_q;
      row_addr <= active_q.row_mirror ? (`FRC_ACTIVE_ROWS - row_q) : row_q;
      pixel_out <= pix_sync_q[1];
    end
  end

  a_strobe_integ: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) && $past(state_q) == FRC_INTEG |-> flash_strobe)
    else $error("strobe low during integration");
  a_trig_three: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(state_q) == FRC_WAIT_TRIG && state_q == FRC_INTEG |-> $past(trig_cnt_q) == 2'h3)
    else $error("integration started without three highs");
  a_target_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ae_target_q == 16'h0800)
    else $error("target reset value wrong");
  a_manual_exp: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !restart_go && tick && state_q == FRC_INTEG && !ae_ctrl_q[0] && cnt_q >= active_q.coarse
    |=> state_q == FRC_READ)
    else $error("manual exposure not used");
  a_col_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) && $past(active_q.col_mirror) |-> col_addr == 16'h000f - $past(col_q))
    else $error("column mirror address wrong");
  a_embed_rows: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !restart_go && tick && state_q == FRC_READ && row_q == 16'h000f && col_q == 16'h000f
    && embed_act_q |=> state_q == FRC_READ)
    else $error("embedded rows missing");
  a_fv_read: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> frame_valid_strobe == ($past(state_q) == FRC_READ))
    else $error("frame valid not tied to readout");
  a_restart_go: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
    restart_q && ctrl_q[2] |-> ##[1:300] state_q == FRC_INTEG)
    else $error("restart did not start frame");
endmodule : frc_readout
`default_nettype wire

// *** test/frc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Downstream receiver: makes the pixel clock and watches the video it gets back.
module frc_partner (
  input wire logic frame_valid_strobe,
  input wire logic line_valid,
  input wire logic [15:0] row_addr,
  input wire logic [15:0] col_addr,
  output logic pixel_out_clock,
  output logic [11:0] pixel_in
);
  int frames = 0;
  int ticks = 0;
  int rows_done = 0;
  logic fv_q = 1'b0;
  logic first = 1'b0;
  logic [15:0] first_row;
  logic [15:0] first_col;
  logic [15:0] last_row;

  // The clock starts off the system clock's phase, and the pixel data changes every tick.
  initial begin
    pixel_out_clock = 1'b0;
    pixel_in = 12'h000;
    #3;
    forever begin
      #16 pixel_out_clock = 1'b1;
      #16 pixel_out_clock = 1'b0;
      pixel_in = pixel_in + 12'h001;
    end
  end

  // Counts frames and line ticks; the first row and column and the last row of each frame are kept.
  always @(posedge pixel_out_clock) begin
    if (frame_valid_strobe === 1'b1 && fv_q === 1'b0) begin
      frames++;
      ticks = 0;
      first = 1'b1;
    end
    if (line_valid === 1'b1) begin
      ticks++;
      if (first) begin
        first_row = row_addr;
        first_col = col_addr;
        first = 1'b0;
      end
      last_row = row_addr;
      rows_done = ticks / 16;
    end
    fv_q = frame_valid_strobe;
  end
endmodule : frc_partner
`default_nettype wire

// *** test/frc_readout_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "frc_defines.svh"
module frc_readout_tb;
  logic pclk, presetn, psel, penable, pwrite, capture_request, pready, pslverr;
  logic fv, lv, flash, rrr, clk_en, err;
  logic rrr_seen = 1'b0;
  logic [11:0] paddr, pix_in, pix_out;
  logic [31:0] pwdata, prdata, rd, r0;
  logic [15:0] row_addr, col_addr;
  logic pxclk;
  int errors, compares, n, f;
  localparam logic [31:0] STRM = 32'h1 << `FRC_CTRL_STREAM;
  localparam logic [31:0] EMB = 32'h1 << `FRC_CTRL_EMBED;

  frc_readout i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_request(capture_request), .pixel_out_clock(pxclk), .pixel_in(pix_in),
    .frame_valid_strobe(fv), .line_valid(lv), .row_addr(row_addr), .col_addr(col_addr),
    .pixel_out(pix_out), .flash_strobe(flash), .row_reset_release(rrr));
  frc_partner i_rx (.frame_valid_strobe(fv), .line_valid(lv), .row_addr(row_addr), .col_addr(col_addr),
    .pixel_out_clock(pxclk), .pixel_in(pix_in));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) if (rrr === 1'b1 && flash === 1'b1) rrr_seen <= 1'b1;

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k == 50) check("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
    check("pslverr", 32'h0, {31'h0, err});
  endtask : rdchk

  // Waits for frame valid (sel 0) or the strobe (sel 1) to reach a level; n holds the cycles taken.
  task wait_sig(input int sel, input logic lvl);
    n = 0;
    while (((sel == 0) ? fv : flash) !== lvl && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20000) check("wait_sig", {31'h0, lvl}, {31'h0, ~lvl});
  endtask : wait_sig

  task frames(input int k);
    repeat (k) begin
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b0);
    end
  endtask : frames

  task results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial begin
    repeat (95000) @(posedge pclk);
    errors++;
    $display("Error watchdog expected done seen hang");
    results;
  end

  initial begin
    {psel, penable, pwrite, capture_request, presetn} = 5'h00;
    clk_en = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ae_target", `FRC_ADDR_AE_TARGET, 32'h00000800);
    rdchk("coarse", `FRC_ADDR_COARSE, 32'h00000010);
    rdchk("gain", `FRC_ADDR_GAIN, 32'h00000020);
    rdchk("unmapped", 12'h100, 32'h0);
    wr(`FRC_ADDR_LINE_PCK, 32'h10);
    wr(`FRC_ADDR_FRAME_LINES, 32'h14);
    wr(`FRC_ADDR_COARSE, 32'h4);
    rdchk("frame_lines", `FRC_ADDR_FRAME_LINES, 32'h14);
    wr(`FRC_ADDR_CTRL, STRM);
    wait_sig(1, 1'b1);
    check("fv_in_integ", 32'h0, {31'h0, fv});
    wait_sig(0, 1'b1);
    check("flash_in_read", 32'h0, {31'h0, flash});
    check("row_release", 32'h1, {31'h0, rrr_seen});
    wait_sig(0, 1'b0);
    check("rows", 32'd16, i_rx.rows_done);
    wait_sig(0, 1'b1);
    wr(`FRC_ADDR_CTRL, STRM | EMB);
    frames(1);
    check("rows_same", 32'd16, i_rx.rows_done);
    frames(1);
    check("rows_embed", 32'd20, i_rx.rows_done);
    wait_sig(0, 1'b1);
    wr(`FRC_ADDR_CTRL, STRM);
    frames(2);
    check("col_plain", 32'h0, {16'h0, i_rx.first_col});
    wait_sig(0, 1'b1);
    wr(`FRC_ADDR_RESAMPLE, 32'h1 << `FRC_RESAMPLE_BIT);
    // Column correction sits outside this block; the host reruns it just before mirroring.
    wr(`FRC_ADDR_READ_MODE, (32'h1 << `FRC_RM_COL_MIRROR) | (32'h1 << `FRC_RM_ROW_MIRROR));
    frames(2);
    check("col_mirror", 32'hf, {16'h0, i_rx.first_col});
    check("row_mirror", 32'h1, {31'h0, i_rx.first_row > i_rx.last_row});
    wait_sig(0, 1'b1);
    wr(`FRC_ADDR_CTRL, STRM | (32'h1 << `FRC_CTRL_RESTART));
    wait_sig(0, 1'b0);
    check("restart_fast", 32'h1, {31'h0, n < 300});
    wait_sig(0, 1'b1);
    rdchk("restart_clear", `FRC_ADDR_CTRL, STRM);
    clk_en <= 1'b0;
    @(posedge pclk);
    r0 = {row_addr, col_addr};
    repeat (100) @(posedge pclk);
    check("freeze", r0, {row_addr, col_addr});
    clk_en <= 1'b1;
    @(negedge pxclk);
    repeat (4) @(posedge pclk);
    check("pixel_out", {20'h0, pix_in}, {20'h0, pix_out});
    // Binning is never enabled while auto exposure runs.
    wr(`FRC_ADDR_AE_TARGET, 32'hfff);
    wr(`FRC_ADDR_AE_CTRL, 32'h1);
    apb(1'b0, `FRC_ADDR_AE_RESULT, 32'h0);
    r0 = rd;
    check("ae_start", {`FRC_GAIN_RST, `FRC_COARSE_RST}, r0);
    frames(4);
    apb(1'b0, `FRC_ADDR_AE_RESULT, 32'h0);
    check("ae_moved", 32'h1, {31'h0, rd[15:0] > r0[15:0]});
    wr(`FRC_ADDR_AE_CTRL, 32'h0);
    wr(`FRC_ADDR_COARSE, 32'h6);
    rdchk("coarse_manual", `FRC_ADDR_COARSE, 32'h6);
    wr(`FRC_ADDR_CTRL, 32'h1 << `FRC_CTRL_SINGLE);
    wait_sig(0, 1'b0);
    repeat (3000) @(posedge pclk);
    f = i_rx.frames;
    capture_request <= 1'b1;
    repeat (2) @(posedge pclk);
    capture_request <= 1'b0;
    repeat (3000) @(posedge pclk);
    check("short_request", f, i_rx.frames);
    capture_request <= 1'b1;
    frames(2);
    check("held_request", f + 2, i_rx.frames);
    wait_sig(0, 1'b1);
    capture_request <= 1'b0;
    wait_sig(0, 1'b0);
    f = i_rx.frames;
    repeat (6000) @(posedge pclk);
    check("released", f, i_rx.frames);
    results;
  end
endmodule : frc_readout_tb
`default_nettype wire
